/* verilog/eea_top.v */
// What this block does
// - Byte write: address, word address, data, stop.
// - Stop after acked data starts programming.
// - Busy programming: ignore bus, never acknowledge.
// - Page of sixteen bytes committed together.
// - Each data byte acked, low address bits increment.
// - Over sixteen bytes wrap within page buffer.
// - Polling: no ack while busy, ack after.
// - Write protect: ack addresses, refuse data byte.
// - Reads started like writes, direction bit one.
// - Shared counter holds last address plus one.
// - Counter rolls from last location to zero.
// - Current read: ack, one byte, master nacks.
// - Repeated start, read address, one byte sent.
// - Master ack asks for the next byte.
// - Reads increment the full address counter.
// - Respond only to matching upper address nibble.
// - Master nack: release data, wait for stop.
`include "eea_defines.vh"
module eea_top #(
  parameter AW      = `EEA_ADDR_W,
  parameter PW      = `EEA_PAGE_W,
  parameter TWR_CYC = `EEA_TWR_CYC
) (
  // Clock and reset
  input  wire REF_CLK,
  input  wire RST_B,
  // Serial bus pins
  input  wire SCL,
  input  wire SDA_IN,
  output reg  SDA_OUT,
  output reg  SDA_OE_B,
  // Write protect pin
  input  wire WP,
  // Programming cycle in progress
  output reg  BUSY
);
  localparam DW = `EEA_DATA_W;
  localparam NPG = 1 << PW;
  // One-hot bus states
  localparam ST_IDLE = 7'h01;
  localparam ST_DEV  = 7'h02;
  localparam ST_WADR = 7'h04;
  localparam ST_WDAT = 7'h08;
  localparam ST_RDAT = 7'h10;
  localparam ST_RACK = 7'h20;
  localparam ST_WAIT = 7'h40;

  // Two-stage synchronisers, then a history stage for edges
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [1:0] wp_s;
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      wp_s  <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], SCL};
      sda_s <= {sda_s[1:0], SDA_IN};
      wp_s  <= {wp_s[0], WP};
    end
  end
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  wire stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  wire sda_v    = sda_s[1];

  // Low address bits advance, page bits stay
  function [AW-1:0] page_inc;
    input [AW-1:0] a;
    begin
      page_inc = {a[AW-1:PW], a[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}};
    end
  endfunction

  reg [6:0]    state;
  reg [3:0]    bitcnt;      // 0..7 data bits, 8 is the ninth clock
  reg [7:0]    shreg;
  reg [AW-1:0] addr;        // shared address counter
  reg [AW-1:0] page_base;
  reg [DW-1:0] pbuf [0:NPG-1];
  reg [NPG-1:0] pvalid;
  reg          have_data;
  reg          ack_drive;
  reg          tx_drive;
  reg [31:0]   twr_cnt;
  reg [PW:0]   cidx;        // commit walk index
  reg          committing;
  reg          mem_we;
  reg [AW-1:0] mem_waddr;
  reg [DW-1:0] mem_wdata;
  wire [DW-1:0] mem_rdata;
  integer i;

  eea_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk   (REF_CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (addr),
    .rdata (mem_rdata)
  );

  // Bus protocol engine; ignored entirely while programming
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state     <= ST_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      addr      <= `EEA_ADDR_RST;
      page_base <= `EEA_ADDR_RST;
      pvalid    <= {NPG{1'b0}};
      have_data <= 1'b0;
      ack_drive <= 1'b0;
      tx_drive  <= 1'b0;
      for (i = 0; i < NPG; i = i + 1) begin
        pbuf[i] <= `EEA_DATA_RST;
      end
    end else if (BUSY) begin
      // Valid marks stay for the commit walk; the first START after the cycle clears them
      state     <= ST_IDLE;
      ack_drive <= 1'b0;
      tx_drive  <= 1'b0;
      have_data <= 1'b0;
    end else if (stop_c) begin
      state     <= ST_IDLE;
      ack_drive <= 1'b0;
      tx_drive  <= 1'b0;
      have_data <= 1'b0;
    end else if (start_c) begin
      // SCL fall that ends START wraps this to zero before the first bit
      state     <= ST_DEV;
      bitcnt    <= 4'hF;
      ack_drive <= 1'b0;
      tx_drive  <= 1'b0;
      have_data <= 1'b0;
      pvalid    <= {NPG{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          ack_drive <= 1'b0;
        end
        ST_DEV, ST_WADR, ST_WDAT: begin
          if (scl_rise && bitcnt < 4'h8) begin
            shreg  <= {shreg[6:0], sda_v};
          end
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              bitcnt <= 4'h8;
              ack_drive <= 1'b0;
              if (state == ST_DEV) begin
                // Match upper nibble only
                ack_drive <= (shreg[7:4] == `EEA_DEV_CODE);
              end else if (state == ST_WADR) begin
                ack_drive <= 1'b1;
                addr      <= shreg;
                page_base <= shreg;
              end else if (!wp_s[1]) begin
                ack_drive <= 1'b1;
                pbuf[addr[PW-1:0]]   <= shreg;
                pvalid[addr[PW-1:0]] <= 1'b1;
                have_data <= 1'b1;
                addr      <= page_inc(addr);
              end else begin
                ack_drive <= 1'b0;
              end
            end else if (bitcnt == 4'h8) begin
              bitcnt    <= 4'h0;
              ack_drive <= 1'b0;
              if (!ack_drive) begin
                state <= ST_WAIT;
              end else if (state == ST_DEV) begin
                if (shreg[0]) begin
                  state    <= ST_RDAT;
                  shreg    <= mem_rdata;
                  tx_drive <= ~mem_rdata[7];
                  addr     <= addr + {{(AW-1){1'b0}}, 1'b1};
                end else begin
                  state <= ST_WADR;
                end
              end else begin
                state <= ST_WDAT;
              end
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        ST_RDAT: begin
          // Shift out on falling edges, MSB first
          if (scl_fall) begin
            if (bitcnt == 4'h7) begin
              bitcnt   <= 4'h0;
              tx_drive <= 1'b0;
              state    <= ST_RACK;
            end else begin
              bitcnt   <= bitcnt + 4'h1;
              tx_drive <= ~shreg[6];
              shreg    <= {shreg[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          // Master ack on the ninth clock decides the next byte
          if (scl_rise) begin
            if (sda_v) begin
              state <= ST_WAIT;
            end else begin
              shreg <= mem_rdata;
            end
          end
          if (scl_fall && state == ST_RACK) begin
            state    <= ST_RDAT;
            tx_drive <= ~shreg[7];
            addr     <= addr + {{(AW-1){1'b0}}, 1'b1};
          end
        end
        ST_WAIT: begin
          ack_drive <= 1'b0;
          tx_drive  <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Programming cycle: commit buffered page while holding off the bus
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      BUSY       <= 1'b0;
      committing <= 1'b0;
      cidx       <= {(PW+1){1'b0}};
      twr_cnt    <= 32'h0;
      mem_we     <= 1'b0;
      mem_waddr  <= `EEA_ADDR_RST;
      mem_wdata  <= `EEA_DATA_RST;
    end else begin
      mem_we <= 1'b0;
      if (!BUSY && stop_c && have_data) begin
        BUSY       <= 1'b1;
        committing <= 1'b1;
        cidx       <= {(PW+1){1'b0}};
        twr_cnt    <= 32'h0;
      end else if (BUSY) begin
        if (committing) begin
          // One location per cycle; far shorter than the cycle time
          if (cidx[PW]) begin
            committing <= 1'b0;
          end else begin
            mem_we    <= pvalid[cidx[PW-1:0]];
            mem_waddr <= {page_base[AW-1:PW], cidx[PW-1:0]};
            mem_wdata <= pbuf[cidx[PW-1:0]];
            cidx      <= cidx + {{PW{1'b0}}, 1'b1};
          end
        end
        if (twr_cnt >= TWR_CYC - 1) begin
          BUSY <= 1'b0;
        end else begin
          twr_cnt <= twr_cnt + 32'h1;
        end
      end
    end
  end

  // Open-drain drive: enable low pulls the line low
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SDA_OUT  <= 1'b0;
      SDA_OE_B <= 1'b1;
    end else begin
      SDA_OUT  <= 1'b0;
      SDA_OE_B <= ~(ack_drive | tx_drive);
    end
  end
endmodule

/* verilog/eea_defines.vh */
`ifndef EEA_DEFINES_VH
`define EEA_DEFINES_VH
// Slave address pattern in the upper four bits
`define EEA_DEV_CODE      4'hA
// Array and page geometry
`define EEA_ADDR_W        8
`define EEA_PAGE_W        4
`define EEA_DATA_W        8
// Programming cycle time in microseconds and derived cycles at 40 MHz
`define EEA_TWR_US        5000
`define EEA_CLK_MHZ       40
`define EEA_TWR_CYC       (`EEA_TWR_US * `EEA_CLK_MHZ)
// Reset values
`define EEA_ADDR_RST      8'h00
`define EEA_DATA_RST      8'h00
`endif

/* verilog/eea_mem.v */
// Array storage with registered read data
module eea_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // Read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Memory content is undefined at power up, as in a blank part
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* tb/eea_chk.sv */
module eea_chk #(
  parameter int TWR_CYC = 2000
) (
  input wire REF_CLK,
  input wire RST_B,
  input wire SCL,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE_B,
  input wire WP,
  input wire BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] n;
  // Length of the current programming cycle
  always @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
      n <= 32'h0;
    else
      n <= BUSY ? n + 32'h1 : 32'h0;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  out_zero_a: assert property (SDA_OUT == 1'b0)
    else $error("data out not low");
  busy_quiet_a: assert property (BUSY |-> SDA_OE_B)
    else $error("drive while busy");
  busy_max_a: assert property (n <= TWR_CYC)
    else $error("busy too long");
  busy_hold_a: assert property ($rose(BUSY) |=> BUSY [*8])
    else $error("busy too short");
  busy_stop_a: assert property ($rose(BUSY) |-> SCL && SDA_IN)
    else $error("busy without stop");
  wp_guard_a: assert property ($rose(BUSY) |-> !WP)
    else $error("program while protected");
  high_stable_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE_B))
    else $error("data moved in clock high");
  drive_low_a: assert property ($fell(SDA_OE_B) |-> !SCL)
    else $error("drive began in clock high");
endmodule
bind eea_top eea_chk #(.TWR_CYC(TWR_CYC)) u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_B(SDA_OE_B), .WP(WP), .BUSY(BUSY));

/* tb/eea_mst.sv */
module eea_mst (
  // Alignment clock
  input  wire  clk,
  // Bus pins, data released means high
  output logic scl,
  output logic sda_o,
  input  wire  sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 250;
  // Idle bus, clock stands high
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // One bit; data moves only while clock low
  task automatic bitx(input logic b, output logic r);
    @(posedge clk) #1 sda_o = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic start();
    @(posedge clk) #1 sda_o = 1'b1;
    #Q scl = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    @(posedge clk) #1 sda_o = 1'b0;
    #Q scl = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Master acks for more, nacks the last byte
  task automatic rbyte(output logic [7:0] d, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(!more, r);
  endtask
endmodule

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       wp = 1'b0;
  wire        scl, sda_o, sda_out, sda_oe_b, busy;
  wire        sda = sda_o & (sda_oe_b | sda_out);
  logic [7:0] mem [256];
  bit         vld [256];
  logic [7:0] cnt = 8'h00;
  logic [7:0] d;
  logic       ack;
  int         miscompares = 0;
  int         tests_run = 0;
  always #12.5 clk = ~clk;
  // Short programming time keeps polling quick
  eea_top #(.TWR_CYC(2000)) u_dut (.REF_CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_B(sda_oe_b), .WP(wp), .BUSY(busy));
  eea_mst u_mst (.clk(clk), .scl(scl), .sda_o(sda_o), .sda(sda));
  // Write lands in page, low bits wrap
  function automatic logic [7:0] pg(input logic [7:0] a, input int k);
    return {a[7:4], a[3:0] + 4'(k)};
  endfunction
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] v;
    int k;
    u_mst.start();
    u_mst.wbyte(8'hA0, ack);
    `CHK("addr ack", 1'b1, ack)
    u_mst.wbyte(a, ack);
    `CHK("word ack", 1'b1, ack)
    cnt = a;
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      u_mst.wbyte(v, ack);
      `CHK("data ack", !wp, ack)
      if (!wp) begin
        mem[pg(a, i)] = v;
        vld[pg(a, i)] = 1'b1;
        cnt = pg(a, i + 1);
      end
    end
    u_mst.stop();
    k = 0;
    if (n > 0 && !wp) begin
      // Poll until the cycle ends; first try must be refused
      do begin
        u_mst.start();
        u_mst.wbyte(8'hA0, ack);
        if (k == 0) `CHK("poll busy", 1'b0, ack)
        k++;
      end while (!ack && k < 20);
      `CHK("poll done", 1'b1, ack)
      u_mst.stop();
    end else `CHK("busy", 1'b0, busy)
  endtask
  task automatic rd(input logic sel, input logic [7:0] a, input int n);
    if (sel) begin
      u_mst.start();
      u_mst.wbyte(8'hA0, ack);
      u_mst.wbyte(a, ack);
      cnt = a;
    end
    u_mst.start();
    u_mst.wbyte(8'hA1, ack);
    `CHK("read ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(d, i < n - 1);
      if (vld[cnt]) `CHK("read data", mem[cnt], d)
      cnt++;
    end
    repeat (6) @(posedge clk);
    `CHK("released", 1'b1, sda_oe_b)
    u_mst.stop();
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hf24a));
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h3C, 1);
    wr(8'hF8, 20);
    wr(8'h00, 16);
    @(posedge clk) #1 wp = 1'b1;
    wr(8'h3C, 1);
    @(posedge clk) #1 wp = 1'b0;
    rd(1'b1, 8'h3C, 1);
    wr(8'hFE, 0);
    rd(1'b0, 8'h00, 4);
    rd(1'b0, 8'h00, 1);
    repeat (6) rd(1'b1, {4'hF, 4'($urandom)}, 1 + $urandom % 3);
    u_mst.start();
    u_mst.wbyte(8'h50, ack);
    `CHK("foreign ack", 1'b0, ack)
    u_mst.stop();
    print_verdict();
  end
  // Hang guard, well beyond the expected run
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule
